// ### logic/oapse_exec.sv
// Executor for the two OR-into-accumulator forms and the page load
//
// How it works
// - Opcode 0001 000f ffff ORs the accumulator with the addressed file register into the accumulator in one cycle, the file register untouched.
// - Both OR forms set the zero flag when the result is 00h and clear it otherwise, touching no other flag.
// - Opcode 1101 kkkk kkkk ORs the accumulator with the low eight opcode bits into the accumulator in one cycle.
// - Opcode 0000 0001 0nnn copies its 3-bit field into status bits 7 to 5, touching no flag, in one cycle.
// - The page field forms program address bits 11 to 9 of every later jump or call.
`timescale 1ns/10ps
`default_nettype none
module oapse_exec (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic instr_valid,
   input wire logic [11:0] instr,
   output logic [4:0] file_addr,
   input wire logic [7:0] file_operand,
   input wire logic branch_req,
   input wire logic [8:0] branch_low,
   output logic [7:0] accum,
   output logic zero_flag,
   output logic [7:0] status_page,
   output logic [2:0] program_bank_select_bits,
   output logic [11:0] branch_addr,
   output logic branch_valid,
   output logic retired
);
   typedef struct packed {
      logic [7:0] acc;
      logic zero;
      logic [2:0] page;
      logic [11:0] baddr;
      logic bvalid;
      logic done;
   } oapse_state_t;

   oapse_state_t cur;
   oapse_state_t next_cur;
   oapse_pkg::oapse_op_t op;
   logic [7:0] imm;
   logic [2:0] page_field;
   logic [7:0] or_result;

   function automatic logic is_zero(input logic [7:0] value);
      return value == oapse_pkg::OAPSE_ZERO_VALUE;
   endfunction

   function automatic logic is_or(input oapse_pkg::oapse_op_t code);
      return code == oapse_pkg::OAPSE_OP_OR_FILE || code == oapse_pkg::OAPSE_OP_OR_IMM;
   endfunction

   oapse_decode u_decode (
      .instr(instr),
      .op(op),
      .file_addr(file_addr),
      .imm(imm),
      .page(page_field)
   );

   // File operand is read combinationally so the OR still retires in one cycle
   always_comb begin
      if (op == oapse_pkg::OAPSE_OP_OR_FILE) begin
         or_result = cur.acc | file_operand;
      end else begin
         or_result = cur.acc | imm;
      end
   end

   always_comb begin
      next_cur = cur;
      next_cur.done = 1'b0;
      next_cur.bvalid = 1'b0;
      if (instr_valid) begin
         next_cur.done = 1'b1;
         case (op)
            oapse_pkg::OAPSE_OP_OR_FILE,
            oapse_pkg::OAPSE_OP_OR_IMM: begin
               next_cur.acc = or_result;
               next_cur.zero = is_zero(or_result);
            end
            oapse_pkg::OAPSE_OP_PAGE: begin
               next_cur.page = page_field;
            end
            default: begin
               next_cur.done = 1'b0;
            end
         endcase
      end
      // Uses the page held now; a page load in this same cycle applies from the next one
      if (branch_req) begin
         next_cur.baddr = {cur.page, branch_low};
         next_cur.bvalid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cur.acc <= oapse_pkg::OAPSE_ACC_RST;
         cur.zero <= oapse_pkg::OAPSE_ZERO_RST;
         cur.page <= oapse_pkg::OAPSE_PAGE_RST;
         cur.baddr <= oapse_pkg::OAPSE_BRANCH_RST;
         cur.bvalid <= 1'b0;
         cur.done <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign accum = cur.acc;
   assign zero_flag = cur.zero;
   assign program_bank_select_bits = cur.page;
   // Only the page field of the status byte lives here; the rest reads zero
   assign status_page = 8'(cur.page) << oapse_pkg::OAPSE_STATUS_PAGE_LSB;
   assign branch_addr = cur.baddr;
   assign branch_valid = cur.bvalid;
   assign retired = cur.done;

   or_file_result_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_OR_FILE
      |=> accum == ($past(accum) | $past(file_operand)) && retired);

   or_imm_result_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_OR_IMM
      |=> accum == ($past(accum) | $past(instr[7:0])) && retired);

   zero_flag_set_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && is_or(op)
      |=> zero_flag == (accum == 8'h00));

   zero_flag_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      !(instr_valid && is_or(op))
      |=> $stable(zero_flag) && $stable(accum));

   page_load_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_PAGE
      |=> program_bank_select_bits == $past(instr[2:0]) && status_page[7:5] == $past(instr[2:0])
          && $stable(zero_flag) && $stable(accum));

   page_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      !(instr_valid && op == oapse_pkg::OAPSE_OP_PAGE) |=> $stable(program_bank_select_bits));

   branch_page_a: assert property (@(posedge clock) disable iff (!arst_n)
      branch_req |=> branch_valid && branch_addr[11:9] == $past(program_bank_select_bits)
          && branch_addr[8:0] == $past(branch_low));

   page_then_branch_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_PAGE ##1 branch_req
      |=> branch_addr[11:9] == $past(instr[2:0], 2));

   // Decode checked against raw opcode bits so a wrong package mask shows up
   or_file_decode_a: assert property (@(posedge clock) disable iff (!arst_n)
      (op == oapse_pkg::OAPSE_OP_OR_FILE) == (instr[11:5] == 7'h08))
      else $error("file OR decode disagrees with opcode bits");

   or_imm_decode_a: assert property (@(posedge clock) disable iff (!arst_n)
      (op == oapse_pkg::OAPSE_OP_OR_IMM) == (instr[11:8] == 4'hd))
      else $error("immediate OR decode disagrees with opcode bits");

   page_decode_a: assert property (@(posedge clock) disable iff (!arst_n)
      (op == oapse_pkg::OAPSE_OP_PAGE) == (instr[11:3] == 9'h002))
      else $error("page decode disagrees with opcode bits");

   file_addr_wire_a: assert property (@(posedge clock) disable iff (!arst_n)
      file_addr == instr[4:0])
      else $error("file address does not follow opcode field");

   imm_field_a: assert property (@(posedge clock) disable iff (!arst_n)
      imm == instr[7:0])
      else $error("immediate field does not follow opcode");

   page_field_a: assert property (@(posedge clock) disable iff (!arst_n)
      page_field == instr[2:0])
      else $error("page field does not follow opcode");

   retire_known_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op != oapse_pkg::OAPSE_OP_NONE
      |=> retired)
      else $error("recognised instruction did not retire in one cycle");

   retire_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
      !(instr_valid && op != oapse_pkg::OAPSE_OP_NONE)
      |=> !retired)
      else $error("retire pulse without a recognised instruction");

   refused_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_NONE
      |=> $stable(accum) && $stable(zero_flag) && $stable(program_bank_select_bits))
      else $error("foreign opcode changed state");

   or_keeps_page_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && is_or(op)
      |=> $stable(program_bank_select_bits))
      else $error("OR changed the page field");

   zero_clear_imm_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_OR_IMM && instr[7:0] != 8'h00
      |=> !zero_flag)
      else $error("zero flag set after nonzero immediate OR");

   zero_set_imm_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_OR_IMM
      && accum == 8'h00 && instr[7:0] == 8'h00
      |=> zero_flag)
      else $error("zero flag clear after zero immediate OR");

   zero_clear_file_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && op == oapse_pkg::OAPSE_OP_OR_FILE && file_operand != 8'h00
      |=> !zero_flag)
      else $error("zero flag set after nonzero file OR");

   // Back to back ORs must each retire; no bubble is allowed
   back_to_back_or_a: assert property (@(posedge clock) disable iff (!arst_n)
      instr_valid && is_or(op) ##1 instr_valid && is_or(op)
      |=> retired && $past(retired))
      else $error("back to back OR lost a retire pulse");

   status_view_a: assert property (@(posedge clock) disable iff (!arst_n)
      status_page == {program_bank_select_bits, 5'h00})
      else $error("status view does not show the page field alone");

   branch_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
      !branch_req
      |=> !branch_valid && $stable(branch_addr))
      else $error("branch output moved without a request");
endmodule
`default_nettype wire

// ### logic/oapse_pkg.sv
// Package of opcode patterns, field positions and reset values for the OR and page executor
package oapse_pkg;
   localparam int OAPSE_IW = 12;
   localparam int OAPSE_DW = 8;
   localparam int OAPSE_PW = 3;
   localparam int OAPSE_FW = 5;
   localparam int OAPSE_LW = 9;
   // OR into accumulator from file register: 0001 000f ffff
   localparam logic [11:0] OAPSE_OR_FILE_MASK = 12'hfe0;
   localparam logic [11:0] OAPSE_OR_FILE_PAT = 12'h100;
   // OR into accumulator from immediate: 1101 kkkk kkkk
   localparam logic [11:0] OAPSE_OR_IMM_MASK = 12'hf00;
   localparam logic [11:0] OAPSE_OR_IMM_PAT = 12'hd00;
   // Page load: 0000 0001 0nnn
   localparam logic [11:0] OAPSE_PAGE_MASK = 12'hff8;
   localparam logic [11:0] OAPSE_PAGE_PAT = 12'h010;
   // Field positions
   localparam int OAPSE_FILE_LSB = 0;
   localparam int OAPSE_IMM_LSB = 0;
   localparam int OAPSE_PAGE_LSB = 0;
   localparam int OAPSE_STATUS_PAGE_LSB = 5;
   localparam int OAPSE_ADDR_PAGE_LSB = 9;
   // Reset values and result constants
   localparam logic [7:0] OAPSE_ACC_RST = 8'h00;
   localparam logic OAPSE_ZERO_RST = 1'b0;
   localparam logic [2:0] OAPSE_PAGE_RST = 3'h0;
   localparam logic [11:0] OAPSE_BRANCH_RST = 12'h000;
   localparam logic [7:0] OAPSE_ZERO_VALUE = 8'h00;
   // Every instruction of the block retires in one cycle
   localparam int OAPSE_EXEC_CYCLES = 1;
   typedef enum logic [1:0] {
      OAPSE_OP_NONE = 2'b00,
      OAPSE_OP_OR_FILE = 2'b01,
      OAPSE_OP_OR_IMM = 2'b10,
      OAPSE_OP_PAGE = 2'b11
   } oapse_op_t;
endpackage

// ### logic/oapse_decode.sv
// Opcode decoder for the OR and page executor
`timescale 1ns/10ps
`default_nettype none
module oapse_decode (
   input wire logic [11:0] instr,
   output oapse_pkg::oapse_op_t op,
   output logic [4:0] file_addr,
   output logic [7:0] imm,
   output logic [2:0] page
);
   always_comb begin
      if ((instr & oapse_pkg::OAPSE_OR_FILE_MASK) == oapse_pkg::OAPSE_OR_FILE_PAT) begin
         op = oapse_pkg::OAPSE_OP_OR_FILE;
      end else if ((instr & oapse_pkg::OAPSE_OR_IMM_MASK) == oapse_pkg::OAPSE_OR_IMM_PAT) begin
         op = oapse_pkg::OAPSE_OP_OR_IMM;
      end else if ((instr & oapse_pkg::OAPSE_PAGE_MASK) == oapse_pkg::OAPSE_PAGE_PAT) begin
         op = oapse_pkg::OAPSE_OP_PAGE;
      end else begin
         op = oapse_pkg::OAPSE_OP_NONE;
      end
   end
   assign file_addr = instr[oapse_pkg::OAPSE_FILE_LSB +: oapse_pkg::OAPSE_FW];
   assign imm = instr[oapse_pkg::OAPSE_IMM_LSB +: oapse_pkg::OAPSE_DW];
   assign page = instr[oapse_pkg::OAPSE_PAGE_LSB +: oapse_pkg::OAPSE_PW];
endmodule
`default_nettype wire

// ### test/oapse_exec_tb.sv
// Self-checking testbench for the OR and page executor
`timescale 1ns/10ps
`default_nettype none
module oapse_exec_tb;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [11:0] instr = 12'h000;
   logic [7:0] file_operand = 8'h00;
   logic branch_req = 1'b0;
   logic [8:0] branch_low = 9'h000;
   logic [4:0] file_addr;
   logic [7:0] accum;
   logic zero_flag;
   logic [7:0] status_page;
   logic [2:0] program_bank_select_bits;
   logic [11:0] branch_addr;
   logic branch_valid;
   logic retired;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   oapse_exec dut_u (.clock(clock), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
      .file_addr(file_addr), .file_operand(file_operand), .branch_req(branch_req),
      .branch_low(branch_low), .accum(accum), .zero_flag(zero_flag), .status_page(status_page),
      .program_bank_select_bits(program_bank_select_bits), .branch_addr(branch_addr),
      .branch_valid(branch_valid), .retired(retired));
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One instruction slot; inputs stand until the next slot rewrites them
   task automatic run(input logic [11:0] op, input logic [7:0] opnd, input logic v,
         input logic br, input logic [8:0] low);
      instr = op;
      file_operand = opnd;
      instr_valid = v;
      branch_req = br;
      branch_low = low;
      #1 chk("file_addr", {7'h00, file_addr}, {7'h00, op[4:0]});
      @(posedge clock);
      @(negedge clock);
   endtask
   task automatic t_refused();
      logic [11:0] ops [4] = '{12'h000, 12'h120, 12'h018, 12'h00c};
      foreach (ops[i]) begin
         run(ops[i], 8'hff, 1'b1, 1'b0, 9'h000);
         chk("acc_refused", {4'h0, accum}, 12'h000);
         chk("retired_refused", {11'h000, retired}, 12'h000);
      end
      run(12'hdff, 8'h00, 1'b0, 1'b0, 9'h000);
      chk("acc_novalid", {4'h0, accum}, 12'h000);
   endtask
   task automatic t_or_forms();
      run(12'hd00, 8'h00, 1'b1, 1'b0, 9'h000);
      chk("zero_set", {11'h000, zero_flag}, 12'h001);
      chk("retired", {11'h000, retired}, 12'h001);
      run(12'h012, 8'h00, 1'b1, 1'b0, 9'h000);
      chk("zero_kept_page", {11'h000, zero_flag}, 12'h001);
      chk("status_page", {4'h0, status_page}, 12'h040);
      run(12'hd50, 8'h00, 1'b1, 1'b0, 9'h000);
      chk("acc_imm", {4'h0, accum}, 12'h050);
      chk("zero_clr", {11'h000, zero_flag}, 12'h000);
      chk("retired_pulse", {11'h000, retired}, 12'h001);
      run(12'h10b, 8'h0f, 1'b1, 1'b0, 9'h000);
      chk("acc_file", {4'h0, accum}, 12'h05f);
      run(12'h11f, 8'ha0, 1'b1, 1'b0, 9'h000);
      chk("acc_file2", {4'h0, accum}, 12'h0ff);
      chk("page_kept", {9'h000, program_bank_select_bits}, 12'h002);
      run(12'h000, 8'h00, 1'b0, 1'b0, 9'h000);
      chk("retired_drop", {11'h000, retired}, 12'h000);
   endtask
   task automatic t_pages();
      for (int p = 0; p < 8; p++) begin
         run(12'h010 | 12'(p), 8'h00, 1'b1, 1'b0, 9'h000);
         chk("status_page", {4'h0, status_page}, {4'h0, 3'(p), 5'h00});
         chk("branch_quiet", {11'h000, branch_valid}, 12'h000);
         run(12'h000, 8'h00, 1'b0, 1'b1, 9'h0a5 ^ 9'(p));
         chk("branch_addr", branch_addr, {3'(p), 9'h0a5 ^ 9'(p)});
         chk("branch_valid", {11'h000, branch_valid}, 12'h001);
         chk("retired_branch", {11'h000, retired}, 12'h000);
      end
      // Page load beside a branch: the branch still sees the old page
      run(12'h013, 8'h00, 1'b1, 1'b1, 9'h1ff);
      chk("branch_old_page", branch_addr, 12'hfff);
      chk("page_new", {9'h000, program_bank_select_bits}, 12'h003);
      chk("acc_untouched", {4'h0, accum}, 12'h0ff);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      chk("acc_rst", {4'h0, accum}, 12'h000);
      chk("status_rst", {4'h0, status_page}, 12'h000);
      t_refused();
      t_or_forms();
      t_pages();
      print_verdict();
   end
endmodule
`default_nettype wire
